// ### core/can_mode_irq.sv
// Mode sequencing and interrupt sources of a CAN controller, Avalon-MM slave
//
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps

module can_mode_irq (
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [5:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        bit_tick_i,
    input  wire logic        frame_end_i,
    input  wire logic        bus_receive_input,
    input  wire logic [1:0]  rxf_store_i,
    input  wire logic [1:0]  rxf_lost_i,
    input  wire logic [7:0]  rxf_count_i,
    input  wire logic        rxb_store_i,
    input  wire logic [3:0]  rxb_idx_i,
    input  wire logic        dlc_err_i,
    input  wire logic        payload_ovf_i,
    input  wire logic        tx_done_i,
    input  wire logic [1:0]  tx_idx_i,
    input  wire logic [1:0]  tx_result_i,
    input  wire logic        cf_store_i,
    input  wire logic        cf_lost_i,
    input  wire logic        cf_tx_done_i,
    input  wire logic        cf_empty_i,
    input  wire logic [5:0]  cf_count_i,
    input  wire logic        hist_store_i,
    input  wire logic        hist_full_i,
    input  wire logic [3:0]  hist_count_i,
    input  wire logic [6:0]  err_det_i,
    input  wire logic [7:0]  rec_i,
    input  wire logic [8:0]  tec_i,
    input  wire logic        recessive11_i,
    input  wire logic        overload_i,
    input  wire logic        arb_lost_i,
    input  wire logic        err_cnt_ovf_i,
    input  wire logic        success_cnt_ovf_i,
    output can_mode_irq_pkg::mode_t global_mode_o,
    output can_mode_irq_pkg::mode_t channel_mode_o,
    output logic             rx_fifo_irq_o,
    output logic             rx_buffer_irq_o,
    output logic             global_err_irq_o,
    output logic             tx_irq_o,
    output logic             cf_rx_irq_o,
    output logic             ch_err_irq_o,
    output logic             wakeup_irq_o
);
    import can_mode_irq_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        mode_t       g_mode;
        mode_t       c_mode;
        logic [1:0]  g_req;
        logic [1:0]  c_req;
        logic [1:0]  g_unit;
        logic [1:0]  c_unit;
        logic [3:0]  g_cnt;
        logic [3:0]  c_cnt;
        logic [15:0] glb_ctrl;
        logic [7:0]  glb_stat;
        logic [15:0] rxb_ie;
        logic [15:0] rxb_nd;
        logic [8:0]  tx_ctrl;
        logic [7:0]  tx_res;
        logic [2:0]  tx_pend;
        logic [18:0] cf_cfg;
        logic [9:0]  ch_ctrl;
        logic [16:0] ch_stat;
        logic        busoff;
        logic [7:0]  bor_cnt;
        logic [5:0]  lock_cnt;
        logic        warn_lvl;
        logic        pass_lvl;
        logic        rx_s1;
        logic        rx_s2;
        logic        rx_s3;
        logic [6:0]  irq;
        logic        wait_r;
        logic [31:0] rdata;
    } st_t;

    st_t st_reg;
    st_t st_next;

    function automatic mode_t to_mode(input logic [1:0] c);
        case (c)
            CODE_OPER:  to_mode = M_OPER;
            CODE_RESET: to_mode = M_RESET;
            CODE_HALT:  to_mode = M_HALT;
            default:    to_mode = M_SLEEP;
        endcase
    endfunction

    function automatic logic [1:0] to_code(input mode_t m);
        case (m)
            M_OPER:  to_code = CODE_OPER;
            M_RESET: to_code = CODE_RESET;
            M_HALT:  to_code = CODE_HALT;
            default: to_code = CODE_SLEEP;
        endcase
    endfunction

    // Unit and count of a transition; U_NONE when not allowed
    function automatic logic [5:0] bound(input logic chan, input mode_t f, input mode_t t);
        bound = {U_NONE, 4'h0};
        if ((f == M_SLEEP && t == M_RESET) || (f == M_RESET && t == M_SLEEP)) begin
            bound = {U_CLK, SLEEP_RESET_CLKS};
        end else if ((f == M_HALT || f == M_OPER) && t == M_RESET) begin
            bound = {U_BIT, TO_RESET_BITS};
        end else if (!chan) begin
            if (f == M_RESET && (t == M_HALT || t == M_OPER))
                bound = {U_CLK, G_RESET_RUN_CLKS};
            else if (f == M_HALT && t == M_OPER)
                bound = {U_CLK, G_HALT_OPER_CLKS};
            else if (f == M_OPER && t == M_HALT)
                bound = {U_FRAME, G_OPER_HALT_FRMS};
        end else begin
            if (f == M_RESET && t == M_HALT)
                bound = {U_BIT, C_RESET_HALT_BITS};
            else if ((f == M_RESET || f == M_HALT) && t == M_OPER)
                bound = {U_BIT, C_TO_OPER_BITS};
            else if (f == M_OPER && t == M_HALT)
                bound = {U_FRAME, C_OPER_HALT_FRMS};
        end
    endfunction

    // Fill level reached: count * 8 >= (code + 1) * depth
    function automatic logic thr_met(input logic [5:0] cnt, input logic [4:0] depth,
                                     input logic [2:0] code);
        thr_met = ({cnt, 3'h0} >= 9'({1'b0, code} + 4'h1) * 9'(depth));
    endfunction

    logic        wr;
    logic [31:0] wm;
    logic [31:0] wkeep;
    logic [31:0] wval;
    logic [5:0]  gb;
    logic [5:0]  cb;
    logic        g_pulse;
    logic        c_pulse;
    logic [16:0] ch_set;
    logic [7:0]  gl_set;
    logic        tx_any;
    logic        early_exit;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_next = st_reg;
        wr = avs_write_i && !st_reg.wait_r;
        wm = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
              {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
        wkeep = avs_writedata_i | ~wm;

        // Bus slave: one wait cycle, then the answer
        st_next.wait_r = !((avs_read_i || avs_write_i) && st_reg.wait_r);

        // Global and channel mode sequencing
        if (wr && avs_address_i == MODE_CTRL_OFS) begin
            wval = ({28'h0, st_reg.c_req, st_reg.g_req} & ~wm) | (avs_writedata_i & wm);
            st_next.g_req = wval[1:0];
            st_next.c_req = wval[3:2];
        end else begin
            wval = 32'h0;
        end
        gb = bound(1'b0, st_reg.g_mode, to_mode(st_reg.g_req));
        cb = bound(1'b1, st_reg.c_mode, to_mode(st_reg.c_req));
        g_pulse = (st_reg.g_unit == U_CLK) || (st_reg.g_unit == U_BIT && bit_tick_i) ||
                  (st_reg.g_unit == U_FRAME && frame_end_i);
        c_pulse = (st_reg.c_unit == U_CLK) || (st_reg.c_unit == U_BIT && bit_tick_i) ||
                  (st_reg.c_unit == U_FRAME && frame_end_i);
        if (st_reg.g_cnt == 4'h0) begin
            if (gb[5:4] != U_NONE) begin
                st_next.g_unit = gb[5:4];
                st_next.g_cnt = (gb[5:4] == U_CLK) ? gb[3:0] - 4'h1 : gb[3:0];
            end
        end else if (g_pulse) begin
            st_next.g_cnt = st_reg.g_cnt - 4'h1;
            if (st_reg.g_cnt == 4'h1)
                st_next.g_mode = to_mode(st_reg.g_req);
        end
        if (st_reg.c_cnt == 4'h0) begin
            if (cb[5:4] != U_NONE) begin
                st_next.c_unit = cb[5:4];
                st_next.c_cnt = (cb[5:4] == U_CLK) ? cb[3:0] - 4'h1 : cb[3:0];
            end
        end else if (c_pulse) begin
            st_next.c_cnt = st_reg.c_cnt - 4'h1;
            if (st_reg.c_cnt == 4'h1)
                st_next.c_mode = to_mode(st_reg.c_req);
        end

        // Plain control registers
        if (wr && avs_address_i == GLB_CTRL_OFS)
            st_next.glb_ctrl = 16'((32'(st_reg.glb_ctrl) & ~wm) | (avs_writedata_i & wm));
        if (wr && avs_address_i == RXB_IE_OFS)
            st_next.rxb_ie = 16'((32'(st_reg.rxb_ie) & ~wm) | (avs_writedata_i & wm));
        if (wr && avs_address_i == TX_CTRL_OFS)
            st_next.tx_ctrl = 9'((32'(st_reg.tx_ctrl) & ~wm) | (avs_writedata_i & wm));
        if (wr && avs_address_i == CH_CTRL_OFS)
            st_next.ch_ctrl = 10'((32'(st_reg.ch_ctrl) & ~wm) | (avs_writedata_i & wm));
        if (wr && avs_address_i == CF_CFG_OFS && st_reg.g_mode == M_RESET)
            st_next.cf_cfg = 19'((32'(st_reg.cf_cfg) & ~wm) | (avs_writedata_i & wm));

        // Global status: dlc, payload, lost x2, cf lost, hist lost, rx fifo pend x2
        gl_set = {rxf_store_i[1] && st_reg.glb_ctrl[5] &&
                      (st_reg.glb_ctrl[7] || thr_met({2'h0, rxf_count_i[7:4]},
                                                     {1'b0, RXF_DEPTH},
                                                     st_reg.glb_ctrl[14:12])),
                  rxf_store_i[0] && st_reg.glb_ctrl[4] &&
                      (st_reg.glb_ctrl[6] || thr_met({2'h0, rxf_count_i[3:0]},
                                                     {1'b0, RXF_DEPTH},
                                                     st_reg.glb_ctrl[10:8])),
                  hist_store_i && hist_full_i,
                  cf_lost_i,
                  rxf_lost_i,
                  payload_ovf_i,
                  dlc_err_i};
        st_next.glb_stat = ((wr && avs_address_i == GLB_STAT_OFS) ?
                            st_reg.glb_stat & wkeep[7:0] : st_reg.glb_stat) | gl_set;

        // Receive buffers
        st_next.rxb_nd = ((wr && avs_address_i == RXB_ND_OFS) ?
                          st_reg.rxb_nd & wkeep[15:0] : st_reg.rxb_nd) |
                         (rxb_store_i ? 16'h0001 << rxb_idx_i : 16'h0000);

        // Transmit results: cleared only by writing 00 to the field
        for (int i = 0; i < 4; i++) begin
            if (wr && avs_address_i == TX_STAT_OFS && wm[2*i] &&
                avs_writedata_i[2*i +: 2] == 2'h0)
                st_next.tx_res[2*i +: 2] = 2'h0;
            if (tx_done_i && tx_idx_i == 2'(i))
                st_next.tx_res[2*i +: 2] = tx_result_i;
        end

        // Common FIFO tx, history, common FIFO rx pending
        st_next.tx_pend = ((wr && avs_address_i == TX_STAT_OFS) ?
                           st_reg.tx_pend & wkeep[10:8] : st_reg.tx_pend) |
            {cf_store_i && !st_reg.cf_cfg[13] &&
                 (st_reg.cf_cfg[12] ||
                  thr_met(cf_count_i, 5'(st_reg.cf_cfg[2:0] * CF_DEPTH_STEP),
                          st_reg.cf_cfg[10:8])),
             hist_store_i && !hist_full_i &&
                 (st_reg.tx_ctrl[7] || hist_count_i >= HIST_IRQ_LVL),
             cf_tx_done_i && st_reg.cf_cfg[13] &&
                 (st_reg.cf_cfg[12] || cf_empty_i)};

        // Channel error sources
        st_next.warn_lvl = rec_i > WARN_LIMIT || tec_i > {1'b0, WARN_LIMIT};
        st_next.pass_lvl = rec_i > PASSIVE_LIMIT || tec_i > {1'b0, PASSIVE_LIMIT};
        st_next.rx_s1 = bus_receive_input;
        st_next.rx_s2 = st_reg.rx_s1;
        st_next.rx_s3 = st_reg.rx_s2;
        ch_set = 17'h0;
        ch_set[6:0] = err_det_i;
        ch_set[7] = |err_det_i;
        ch_set[8] = st_next.warn_lvl && !st_reg.warn_lvl;
        ch_set[9] = st_next.pass_lvl && !st_reg.pass_lvl;
        ch_set[12] = overload_i;
        ch_set[14] = arb_lost_i;
        ch_set[15] = err_cnt_ovf_i;
        ch_set[16] = success_cnt_ovf_i;

        // Bus lock: consecutive dominant bits in operation mode
        if (st_reg.c_mode != M_OPER || (bit_tick_i && st_reg.rx_s2)) begin
            st_next.lock_cnt = 6'h0;
        end else if (bit_tick_i && st_reg.lock_cnt != LOCK_BITS) begin
            st_next.lock_cnt = st_reg.lock_cnt + 6'h1;
            ch_set[13] = (st_reg.lock_cnt == LOCK_BITS - 6'h1);
        end

        // Bus off entry and recovery
        early_exit = (st_next.c_mode != M_OPER) ||
                     (wr && avs_address_i == MODE_CTRL_OFS && wval[4]);
        if (!st_reg.busoff) begin
            st_next.bor_cnt = 8'h0;
            if (tec_i > BUSOFF_LIMIT) begin
                st_next.busoff = 1'b1;
                ch_set[10] = 1'b1;
            end
        end else if (early_exit) begin
            st_next.busoff = 1'b0;
        end else if (recessive11_i) begin
            st_next.bor_cnt = st_reg.bor_cnt + 8'h1;
            if (st_reg.bor_cnt == BOR_COUNT - 8'h1) begin
                st_next.busoff = 1'b0;
                ch_set[11] = 1'b1;
            end
        end
        st_next.ch_stat = ((wr && avs_address_i == CH_STAT_OFS) ?
                           st_reg.ch_stat & wkeep[16:0] : st_reg.ch_stat) | ch_set;

        // Interrupt outputs
        tx_any = 1'b0;
        for (int i = 0; i < 4; i++) begin
            tx_any = tx_any || (st_reg.tx_res[2*i+1] && st_reg.tx_ctrl[i]) ||
                     (st_reg.tx_res[2*i +: 2] == 2'h1 && st_reg.tx_ctrl[4]);
        end
        st_next.irq[0] = |(st_reg.glb_stat[7:6] & st_reg.glb_ctrl[5:4]);
        st_next.irq[1] = |(st_reg.rxb_nd & st_reg.rxb_ie);
        st_next.irq[2] = (st_reg.glb_stat[0] && st_reg.glb_ctrl[0]) ||
                         (st_reg.glb_stat[1] && st_reg.glb_ctrl[3]) ||
                         ((|st_reg.glb_stat[4:2]) && st_reg.glb_ctrl[1]) ||
                         (st_reg.glb_stat[5] && st_reg.glb_ctrl[2]);
        st_next.irq[3] = tx_any || (st_reg.tx_pend[0] && st_reg.tx_ctrl[5]) ||
                         (st_reg.tx_pend[1] && st_reg.tx_ctrl[6]);
        st_next.irq[4] = st_reg.tx_pend[2] && st_reg.tx_ctrl[8];
        st_next.irq[5] = |(st_reg.ch_stat[16:7] & st_reg.ch_ctrl);
        st_next.irq[6] = st_reg.rx_s3 && !st_reg.rx_s2;

        // Read data
        case (avs_address_i)
            MODE_CTRL_OFS: st_next.rdata = {18'h0, st_reg.c_cnt != 4'h0,
                                            st_reg.g_cnt != 4'h0, to_code(st_reg.c_mode),
                                            to_code(st_reg.g_mode), 4'h0,
                                            st_reg.c_req, st_reg.g_req};
            GLB_CTRL_OFS:  st_next.rdata = {16'h0, st_reg.glb_ctrl};
            GLB_STAT_OFS:  st_next.rdata = {24'h0, st_reg.glb_stat};
            RXB_IE_OFS:    st_next.rdata = {16'h0, st_reg.rxb_ie};
            RXB_ND_OFS:    st_next.rdata = {16'h0, st_reg.rxb_nd};
            TX_CTRL_OFS:   st_next.rdata = {23'h0, st_reg.tx_ctrl};
            TX_STAT_OFS:   st_next.rdata = {21'h0, st_reg.tx_pend, st_reg.tx_res};
            CF_CFG_OFS:    st_next.rdata = {13'h0, st_reg.cf_cfg};
            CH_CTRL_OFS:   st_next.rdata = {22'h0, st_reg.ch_ctrl};
            CH_STAT_OFS:   st_next.rdata = {14'h0, st_reg.busoff, st_reg.ch_stat};
            default:       st_next.rdata = 32'h0;
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            st_reg        <= '0;
            st_reg.g_mode <= M_SLEEP;
            st_reg.c_mode <= M_SLEEP;
            st_reg.g_req  <= MODE_RST_CODE;
            st_reg.c_req  <= MODE_RST_CODE;
            st_reg.g_unit <= U_NONE;
            st_reg.c_unit <= U_NONE;
            st_reg.cf_cfg <= CF_CFG_RST;
            st_reg.rx_s1  <= 1'b1;
            st_reg.rx_s2  <= 1'b1;
            st_reg.rx_s3  <= 1'b1;
            st_reg.wait_r <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata_o    = st_reg.rdata;
    assign avs_waitrequest_o = st_reg.wait_r;
    assign global_mode_o     = st_reg.g_mode;
    assign channel_mode_o    = st_reg.c_mode;
    assign rx_fifo_irq_o     = st_reg.irq[0];
    assign rx_buffer_irq_o   = st_reg.irq[1];
    assign global_err_irq_o  = st_reg.irq[2];
    assign tx_irq_o          = st_reg.irq[3];
    assign cf_rx_irq_o       = st_reg.irq[4];
    assign ch_err_irq_o      = st_reg.irq[5];
    assign wakeup_irq_o      = st_reg.irq[6];
endmodule // can_mode_irq

// ### core/can_mode_irq_pkg.sv
// Constants, types and register map of the CAN mode and interrupt block
package can_mode_irq_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [5:0] MODE_CTRL_OFS = 6'h00;
    localparam logic [5:0] GLB_CTRL_OFS  = 6'h04;
    localparam logic [5:0] GLB_STAT_OFS  = 6'h08;
    localparam logic [5:0] RXB_IE_OFS    = 6'h0C;
    localparam logic [5:0] RXB_ND_OFS    = 6'h10;
    localparam logic [5:0] TX_CTRL_OFS   = 6'h14;
    localparam logic [5:0] TX_STAT_OFS   = 6'h18;
    localparam logic [5:0] CF_CFG_OFS    = 6'h1C;
    localparam logic [5:0] CH_CTRL_OFS   = 6'h20;
    localparam logic [5:0] CH_STAT_OFS   = 6'h24;

    // ****************************************************************
    // Mode codes and states
    // ****************************************************************
    localparam logic [1:0] CODE_OPER  = 2'h0;
    localparam logic [1:0] CODE_RESET = 2'h1;
    localparam logic [1:0] CODE_HALT  = 2'h2;
    localparam logic [1:0] CODE_SLEEP = 2'h3;

    typedef enum logic [3:0] {
        M_OPER  = 4'h1,
        M_RESET = 4'h2,
        M_HALT  = 4'h4,
        M_SLEEP = 4'h8
    } mode_t;

    // Units a transition waits on
    localparam logic [1:0] U_CLK   = 2'h0;
    localparam logic [1:0] U_BIT   = 2'h1;
    localparam logic [1:0] U_FRAME = 2'h2;
    localparam logic [1:0] U_NONE  = 2'h3;

    // ****************************************************************
    // Transition bounds and counts
    // ****************************************************************
    localparam logic [3:0] SLEEP_RESET_CLKS = 4'h3;
    localparam logic [3:0] G_RESET_RUN_CLKS = 4'hA;
    localparam logic [3:0] G_HALT_OPER_CLKS = 4'h3;
    localparam logic [3:0] TO_RESET_BITS    = 4'h2;
    localparam logic [3:0] G_OPER_HALT_FRMS = 4'h3;
    localparam logic [3:0] C_RESET_HALT_BITS = 4'h3;
    localparam logic [3:0] C_TO_OPER_BITS   = 4'h4;
    localparam logic [3:0] C_OPER_HALT_FRMS = 4'h2;

    localparam logic [7:0] WARN_LIMIT    = 8'h5F;
    localparam logic [7:0] PASSIVE_LIMIT = 8'h7F;
    localparam logic [8:0] BUSOFF_LIMIT  = 9'h0FF;
    localparam logic [7:0] BOR_COUNT     = 8'h80;
    localparam logic [5:0] LOCK_BITS     = 6'h20;
    localparam logic [3:0] HIST_IRQ_LVL  = 4'h6;
    localparam logic [3:0] RXF_DEPTH     = 4'h8;
    localparam logic [2:0] CF_DEPTH_STEP = 3'h4;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [1:0] MODE_RST_CODE = 2'h3;
    localparam logic [18:0] CF_CFG_RST   = 19'h00000;
endpackage

// ### dv/can_bus_model.sv
// Far-side bus model: bit ticks and the receive pin
`timescale 1ns/1ps
module can_bus_model (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic dominant_i,
    output logic      bit_tick_o,
    output logic      rx_o
);
    logic [1:0] div_reg;
    always_ff @(posedge clk_i) begin
        div_reg    <= resetn_i ? div_reg + 2'h1 : 2'h0;
        bit_tick_o <= resetn_i && div_reg == 2'h3;
        rx_o       <= !dominant_i;
    end
endmodule // can_bus_model

// ### dv/can_mode_irq_asserts.sv
// Port checks of the CAN mode and interrupt block
`timescale 1ns/1ps
module can_mode_irq_asserts (
    input wire logic ref_clk_i, resetn_i, avs_read_i, avs_write_i, avs_waitrequest_o,
    input wire logic bus_receive_input, wakeup_irq_o, dlc_err_i, payload_ovf_i,
    input wire logic cf_lost_i, hist_store_i, tx_done_i, cf_tx_done_i, ch_err_irq_o,
    input wire logic global_err_irq_o, tx_irq_o,
    input wire logic [1:0] rxf_lost_i,
    input wire can_mode_irq_pkg::mode_t global_mode_o, channel_mode_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("no answer after one wait");
    a_wait_back: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    a_wake_pulse: assert property (wakeup_irq_o |=> !wakeup_irq_o)
        else $error("wakeup too long");
    a_wake_cause: assert property (wakeup_irq_o |->
        !$past(bus_receive_input, 2) && $past(bus_receive_input, 6)) else $error("bad wakeup");
    a_mode_hot: assert property ($onehot(global_mode_o) && $onehot(channel_mode_o))
        else $error("mode not one-hot");
    a_gerr_cause: assert property ($rose(global_err_irq_o) |-> $past(avs_write_i, 2) ||
        $past(dlc_err_i || payload_ovf_i || cf_lost_i || |rxf_lost_i || hist_store_i, 2))
        else $error("global error without cause");
    a_tx_cause: assert property ($rose(tx_irq_o) |-> $past(avs_write_i, 2) ||
        $past(tx_done_i || cf_tx_done_i || hist_store_i, 2)) else $error("tx irq without cause");
    a_irq_fall: assert property ($fell(global_err_irq_o) || $fell(tx_irq_o) ||
        $fell(ch_err_irq_o) |-> $past(avs_write_i, 2)) else $error("irq fell without write");
    c_wake: cover property (wakeup_irq_o);
    c_gerr: cover property ($rose(global_err_irq_o));
    c_tx: cover property ($rose(tx_irq_o));
endmodule // can_mode_irq_asserts
bind can_mode_irq can_mode_irq_asserts can_mode_irq_asserts_inst (.*);

// ### dv/test_can_mode_irq.sv
// Self-checking bench of the CAN mode and interrupt block
`timescale 1ns/1ps
module test_can_mode_irq;
    import can_mode_irq_pkg::*;
    logic ref_clk_i = 0, resetn_i = 0, avs_read_i = 0, avs_write_i = 0, dom = 0, woke = 0;
    logic frame_end_i = 0, rxb_store_i = 0, dlc_err_i = 0, payload_ovf_i = 0, tx_done_i = 0;
    logic cf_store_i = 0, cf_lost_i = 0, cf_tx_done_i = 0, cf_empty_i = 0, hist_store_i = 0;
    logic hist_full_i = 0, recessive11_i = 0, overload_i = 0, arb_lost_i = 0;
    logic err_cnt_ovf_i = 0, success_cnt_ovf_i = 0, bit_tick_i, bus_receive_input;
    logic [5:0]  avs_address_i = 0, cf_count_i = 0;
    logic [31:0] avs_writedata_i = 0, avs_readdata_o, q;
    logic [3:0]  avs_byteenable_i = 4'hF, rxb_idx_i = 0, hist_count_i = 0;
    logic [1:0]  rxf_store_i = 0, rxf_lost_i = 0, tx_idx_i = 0, tx_result_i = 0;
    logic [7:0]  rxf_count_i = 0, rec_i = 0;
    logic [8:0]  tec_i = 0;
    logic [6:0]  err_det_i = 0;
    logic avs_waitrequest_o, rx_fifo_irq_o, rx_buffer_irq_o, global_err_irq_o, tx_irq_o;
    logic cf_rx_irq_o, ch_err_irq_o, wakeup_irq_o;
    mode_t global_mode_o, channel_mode_o;
    int err_total = 0, check_count = 0, cyc = 0, n;
    always #4 ref_clk_i = ~ref_clk_i;
    can_mode_irq can_mode_irq_inst (.*);
    can_bus_model can_bus_model_inst (.clk_i(ref_clk_i), .resetn_i(resetn_i),
        .dominant_i(dom), .bit_tick_o(bit_tick_i), .rx_o(bus_receive_input));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", s, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge ref_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 0;
        avs_read_i <= 0;
    endtask
    task automatic tk(input int c);
        repeat (c) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic mode_wait(input mode_t g, c, input int lim);
        n = 0;
        while ((global_mode_o !== g || channel_mode_o !== c) && n < 40) begin
            tk(1);
            n++;
        end
        chk("mode time", n <= lim, 1);
    endtask
    always @(posedge ref_clk_i) begin
        if (wakeup_irq_o === 1'b1) woke <= 1;
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            end_sim();
        end
    end
    initial begin
        repeat (2) @(posedge ref_clk_i);
        resetn_i <= 1;
        tk(1);
        chk("modes", {global_mode_o, channel_mode_o}, {M_SLEEP, M_SLEEP});
        bus(0, MODE_CTRL_OFS, 0);
        chk("mode reg", q, 32'h00000F0F);
        bus(0, 6'h3C, 0);
        chk("unmapped", q, 0);
        bus(1, MODE_CTRL_OFS, 32'h5);
        mode_wait(M_RESET, M_RESET, 3);
        bus(1, CF_CFG_OFS, 32'h1001);
        bus(0, CF_CFG_OFS, 0);
        chk("cf cfg", q, 32'h1001);
        bus(1, MODE_CTRL_OFS, 32'h4);
        mode_wait(M_OPER, M_RESET, 10);
        bus(1, MODE_CTRL_OFS, 32'h0);
        mode_wait(M_OPER, M_OPER, 17);
        bus(1, GLB_CTRL_OFS, 32'h1);
        dlc_err_i <= 1;
        tk(1);
        dlc_err_i <= 0;
        tk(1);
        chk("gerr set", global_err_irq_o, 1);
        bus(1, GLB_STAT_OFS, 32'hFF);
        tk(1);
        chk("gerr kept", global_err_irq_o, 1);
        bus(1, GLB_STAT_OFS, 0);
        tk(1);
        chk("gerr clr", global_err_irq_o, 0);
        bus(1, GLB_CTRL_OFS, 32'h211);
        rxf_count_i <= 8'h02;
        rxf_store_i <= 2'h1;
        tk(1);
        rxf_store_i <= 2'h0;
        tk(1);
        chk("rxf below", rx_fifo_irq_o, 0);
        rxf_count_i <= 8'h03;
        rxf_store_i <= 2'h1;
        tk(1);
        rxf_store_i <= 2'h0;
        tk(1);
        chk("rxf level", rx_fifo_irq_o, 1);
        bus(1, RXB_IE_OFS, 32'h8);
        rxb_idx_i <= 4'h3;
        rxb_store_i <= 1;
        tk(1);
        rxb_store_i <= 0;
        tk(1);
        chk("rxb irq", rx_buffer_irq_o, 1);
        bus(1, RXB_ND_OFS, 0);
        tk(1);
        chk("rxb clr", rx_buffer_irq_o, 0);
        bus(1, TX_CTRL_OFS, 32'h101);
        tx_result_i <= 2'h2;
        tx_done_i <= 1;
        cf_store_i <= 1;
        tk(1);
        tx_done_i <= 0;
        cf_store_i <= 0;
        tk(1);
        chk("tx irq", tx_irq_o, 1);
        chk("cf rx irq", cf_rx_irq_o, 1);
        bus(0, TX_STAT_OFS, 0);
        chk("tx result", q[1:0], 2'h2);
        bus(1, TX_STAT_OFS, 0);
        tk(1);
        chk("tx clr", tx_irq_o, 0);
        chk("cf rx clr", cf_rx_irq_o, 0);
        rec_i <= WARN_LIMIT;
        bus(0, CH_STAT_OFS, 0);
        chk("warn 95", q[8], 0);
        rec_i <= WARN_LIMIT + 8'h1;
        tk(2);
        bus(0, CH_STAT_OFS, 0);
        chk("warn 96", q[8], 1);
        bus(1, CH_CTRL_OFS, 32'h40);
        dom <= 1;
        tk(140);
        chk("wake", woke, 1);
        chk("lock irq", ch_err_irq_o, 1);
        dom <= 0;
        bus(1, CH_STAT_OFS, 0);
        tk(1);
        chk("lock clr", ch_err_irq_o, 0);
        end_sim();
    end
endmodule // test_can_mode_irq
